//--- int_enable_cfg.svh
// Register address, field positions and reset values of the interrupt enable block
`ifndef INT_ENABLE_CFG_SVH
`define INT_ENABLE_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define IEN_ADDR          8'ha8

// ****************************************
// Field positions
// ****************************************
`define IEN_EXT0_BIT      0
`define IEN_TMR0_BIT      1
`define IEN_EXT1_BIT      2
`define IEN_TMR1_BIT      3
`define IEN_SER_BIT       4
`define IEN_TMR2_BIT      5
`define IEN_RSVD_BIT      6
`define IEN_GLOBAL_BIT    7
`define IEN_SRC_CNT       6

// ****************************************
// Reset and fixed values
// ****************************************
`define IEN_SRC_RESET     6'h00
`define IEN_GLOBAL_RESET  1'b0
`define IEN_RSVD_VALUE    1'b1

`endif

//--- int_enable_pkg.sv
// Types shared by the interrupt enable block
`default_nettype none
package int_enable_pkg;
   typedef logic [5:0]  src_vec_t;
   typedef logic [7:0]  byte_t;
   typedef logic [31:0] word_t;
endpackage
`default_nettype wire

//--- int_gate_if.sv
// Enable bits passed from the register file to the request gate
`timescale 1ns/10ps
`default_nettype none
interface int_gate_if;
   import int_enable_pkg::*;
   src_vec_t src_enable;
   logic     global_enable;
   modport ctrl (output src_enable, output global_enable);
   modport gate (input src_enable, input global_enable);
endinterface
`default_nettype wire

//--- int_source_gate.sv
// Qualifies pending interrupt requests with the enable bits
`timescale 1ns/10ps
`default_nettype none
`include "int_enable_cfg.svh"
module int_source_gate
   import int_enable_pkg::*;
#(
   parameter int N_SRC = `IEN_SRC_CNT
) (
   // Clock and reset
   input  wire logic  pclk,
   input  wire logic  presetn,
   // Enable bits
   int_gate_if.gate   en_if,
   // Requests
   input  wire logic  [N_SRC-1:0] pending,
   output logic       [N_SRC-1:0] qualified_r
);
   if (N_SRC != `IEN_SRC_CNT) begin
      $error("N_SRC must match the enable register");
   end

   // ****************************************
   // Gating
   // ****************************************
   wire logic [N_SRC-1:0] qualified_nxt;
   assign qualified_nxt = pending & en_if.src_enable & {N_SRC{en_if.global_enable}};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qualified_r <= '0;
      end else begin
         qualified_r <= qualified_nxt;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   ext0_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      qualified_r[`IEN_EXT0_BIT] == $past(pending[`IEN_EXT0_BIT] & en_if.src_enable[`IEN_EXT0_BIT]
                                          & en_if.global_enable))
      else $error("External 0 request not qualified by its enable");
   src_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      (en_if.src_enable == '0) |=> (qualified_r == '0))
      else $error("Disabled source passed a request");
   src_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      en_if.global_enable && (en_if.src_enable == '1) |=> (qualified_r == $past(pending)))
      else $error("Enabled source request did not pass");
   global_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !en_if.global_enable [*2] |-> (qualified_r == '0))
      else $error("Request passed with global enable clear");
endmodule
`default_nettype wire

//--- int_enable_top.sv
// Interrupt source enable register with APB access and request gating
// Notes on behaviour
// - Enable register at 0xa8: bit7 global, bits5..0 timer2,serial,timer1,ext1,timer0,ext0.
// - Bit 0 enables external interrupt 0 requests.
// - A source whose enable bit is zero never passes a request.
// - A source whose enable bit is one passes requests when globally enabled.
// - Bit 6 is reserved: reads one, writes ignored.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "int_enable_cfg.svh"
module int_enable_top
   import int_enable_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Interrupt requests
   input  wire logic [5:0]        pending,
   output logic      [5:0]        qualified
);
   // Refuse an address bus too narrow for the register offset
   if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
   end

   // ****************************************
   // Helpers
   // ****************************************
   // Byte image of the enable register as software reads it
   function automatic byte_t pack_view(logic global_bit, src_vec_t src_bits);
      return {global_bit, `IEN_RSVD_VALUE, src_bits};
   endfunction

   // ****************************************
   // Address decode
   // ****************************************
   wire logic hit;
   wire logic setup;
   wire logic wr_take;
   assign hit     = (paddr == ADDR_W'(`IEN_ADDR));
   assign setup   = psel & ~penable;
   assign wr_take = psel & penable & pwrite & hit;

   // ****************************************
   // Enable register
   // ****************************************
   src_vec_t src_en_r;
   src_vec_t src_en_nxt;
   logic     global_en_r;
   logic     global_en_nxt;
   assign src_en_nxt    = wr_take ? pwdata[`IEN_TMR2_BIT:`IEN_EXT0_BIT] : src_en_r;
   assign global_en_nxt = wr_take ? pwdata[`IEN_GLOBAL_BIT] : global_en_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_en_r    <= `IEN_SRC_RESET;
         global_en_r <= `IEN_GLOBAL_RESET;
      end else begin
         src_en_r    <= src_en_nxt;
         global_en_r <= global_en_nxt;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   wire byte_t reg_view;
   assign reg_view = pack_view(global_en_r, src_en_r);

   logic  [31:0] prdata_r;
   logic         pslverr_r;
   wire   [31:0] prdata_nxt;
   wire logic    pslverr_nxt;
   assign prdata_nxt  = setup ? ((hit && !pwrite) ? {24'h000000, reg_view} : 32'h00000000) : prdata_r;
   assign pslverr_nxt = setup ? ~hit : pslverr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = psel & penable;
   assign pslverr = psel & penable & pslverr_r;

   // ****************************************
   // Request gate
   // ****************************************
   int_gate_if en_if ();
   assign en_if.src_enable    = src_en_r;
   assign en_if.global_enable = global_en_r;

   int_source_gate #(
      .N_SRC       (`IEN_SRC_CNT)
   ) u_gate (
      .pclk        (pclk),
      .presetn     (presetn),
      .en_if       (en_if),
      .pending     (pending),
      .qualified_r (qualified)
   );

   // ****************************************
   // Checks
   // ****************************************
   reg_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr_take |=> (src_en_r == $past(pwdata[5:0])) && (global_en_r == $past(pwdata[7])))
      else $error("Enable register write not stored");
   reg_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && hit && !pwrite) ##1 (psel && penable) |-> (prdata[7:0] == {global_en_r, 1'b1, src_en_r}))
      else $error("Enable register read value wrong");
   rsvd_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pwrite && !pslverr) |-> prdata[6] && (prdata[31:8] == 24'h000000))
      else $error("Reserved bit did not read as one");
   hold_reg_a: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_take |=> $stable(src_en_r) && $stable(global_en_r))
      else $error("Enable register changed without a write");
   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !hit) ##1 (psel && penable) |-> pslverr && (prdata == 32'h00000000))
      else $error("Unmapped access not flagged");
   gate_path_a: assert property (@(posedge pclk) disable iff (!presetn)
      (qualified != 6'h00) |-> $past(global_en_r) && (qualified == ($past(pending) & $past(src_en_r))))
      else $error("Qualified request without matching enable");

   // ****************************************
   // Checks: bus answer
   // ****************************************
   mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && hit) ##1 (psel && penable) |-> !pslverr)
      else $error("Mapped access flagged as error");
   idle_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
      !(psel && penable) |-> !pready && !pslverr)
      else $error("Bus answer outside an access phase");
   access_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable) |-> pready)
      else $error("Access phase without ready");
   rd_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !setup |=> $stable(prdata))
      else $error("Read data changed outside a setup cycle");
   rd_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
      prdata[31:8] == 24'h000000)
      else $error("Upper read data bits not zero");
   wr_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && pwrite) |=> (prdata == 32'h00000000))
      else $error("Write setup left read data behind");
   unmapped_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !hit) |=> $stable(src_en_r) && $stable(global_en_r))
      else $error("Write to another address changed the register");

   // ****************************************
   // Checks: reset
   // ****************************************
   reset_reg_a: assert property (@(posedge pclk)
      $rose(presetn) |-> (src_en_r == `IEN_SRC_RESET) && (global_en_r == `IEN_GLOBAL_RESET))
      else $error("Enable register not cleared by reset");
   reset_out_a: assert property (@(posedge pclk)
      $rose(presetn) |-> (qualified == 6'h00) && (prdata == 32'h00000000))
      else $error("Outputs not cleared by reset");
   reset_bus_a: assert property (@(posedge pclk)
      $rose(presetn) |-> !pready && !pslverr)
      else $error("Bus answer right after reset");

   // ****************************************
   // Checks: request gate
   // ****************************************
   gate_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(global_en_r) |-> (qualified == 6'h00))
      else $error("Request passed with global enable clear");
   gate_on_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(global_en_r) |-> (qualified == ($past(pending) & $past(src_en_r))))
      else $error("Globally enabled requests not gated by their own bits");
   ext0_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(global_en_r && src_en_r[`IEN_EXT0_BIT] && pending[`IEN_EXT0_BIT]) |-> qualified[`IEN_EXT0_BIT])
      else $error("External 0 request lost");
   tmr0_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(global_en_r && src_en_r[`IEN_TMR0_BIT] && pending[`IEN_TMR0_BIT]) |-> qualified[`IEN_TMR0_BIT])
      else $error("Timer 0 request lost");
   ext1_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(global_en_r && src_en_r[`IEN_EXT1_BIT] && pending[`IEN_EXT1_BIT]) |-> qualified[`IEN_EXT1_BIT])
      else $error("External 1 request lost");
   tmr1_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(global_en_r && src_en_r[`IEN_TMR1_BIT] && pending[`IEN_TMR1_BIT]) |-> qualified[`IEN_TMR1_BIT])
      else $error("Timer 1 request lost");
   ser_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(global_en_r && src_en_r[`IEN_SER_BIT] && pending[`IEN_SER_BIT]) |-> qualified[`IEN_SER_BIT])
      else $error("Serial request lost");
   tmr2_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(global_en_r && src_en_r[`IEN_TMR2_BIT] && pending[`IEN_TMR2_BIT]) |-> qualified[`IEN_TMR2_BIT])
      else $error("Timer 2 request lost");
   ext0_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(src_en_r[`IEN_EXT0_BIT]) |-> !qualified[`IEN_EXT0_BIT])
      else $error("Disabled external 0 request passed");
   tmr0_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(src_en_r[`IEN_TMR0_BIT]) |-> !qualified[`IEN_TMR0_BIT])
      else $error("Disabled timer 0 request passed");
   ext1_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(src_en_r[`IEN_EXT1_BIT]) |-> !qualified[`IEN_EXT1_BIT])
      else $error("Disabled external 1 request passed");
   tmr1_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(src_en_r[`IEN_TMR1_BIT]) |-> !qualified[`IEN_TMR1_BIT])
      else $error("Disabled timer 1 request passed");
   ser_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(src_en_r[`IEN_SER_BIT]) |-> !qualified[`IEN_SER_BIT])
      else $error("Disabled serial request passed");
   tmr2_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(src_en_r[`IEN_TMR2_BIT]) |-> !qualified[`IEN_TMR2_BIT])
      else $error("Disabled timer 2 request passed");
endmodule
`default_nettype wire

//--- irq_source_model.sv
// Behavioural interrupt request sources feeding the enable block
`timescale 1ns/10ps
`default_nettype none
module irq_source_model
   import int_enable_pkg::*;
(
   // Clock and reset
   input  wire logic     pclk,
   input  wire logic     presetn,
   // Request pattern and raised requests
   input  wire src_vec_t req_set,
   output var  src_vec_t pending
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) pending <= 6'h00;
      else pending <= req_set;
   end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the interrupt enable register block
`timescale 1ns/10ps
`default_nettype none
`include "int_enable_cfg.svh"
module testbench
   import int_enable_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   word_t pwdata = 32'h0, prdata, rd;
   src_vec_t req_set = 6'h00, pending, qualified;
   int bad_count = 0, num_checks = 0;
   always #10 pclk = ~pclk;
   irq_source_model irq_source_model_inst (.pclk(pclk), .presetn(presetn), .req_set(req_set), .pending(pending));
   int_enable_top int_enable_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pending(pending), .qualified(qualified));
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic test_done();
      if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input word_t got, input word_t exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(logic wr, logic [7:0] a, word_t wd);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n < 20) begin
         rd = prdata;
         err = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end else begin
         bad_count++;
         test_done();
      end
   endtask
   task automatic gate(byte_t en, src_vec_t req, src_vec_t exp);
      apb(1'b1, `IEN_ADDR, {24'h0, en});
      req_set <= req;
      repeat (4) @(posedge pclk);
      chk({26'h0, qualified}, {26'h0, exp});
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic reset_read();
      apb(1'b0, `IEN_ADDR, 32'h0);
      chk(rd, 32'h40);
   endtask
   task automatic reserved_bit();
      apb(1'b1, `IEN_ADDR, 32'h3f);
      apb(1'b0, `IEN_ADDR, 32'h0);
      chk(rd, 32'h7f);
      apb(1'b1, `IEN_ADDR, 32'hff);
      apb(1'b0, `IEN_ADDR, 32'h0);
      chk(rd, 32'hff);
   endtask
   task automatic each_source();
      for (int i = 0; i < 6; i++) gate(8'h80 | (8'h01 << i), 6'h3f, 6'h01 << i);
      gate(8'hbf, 6'h15, 6'h15);
   endtask
   task automatic global_off();
      gate(8'h3f, 6'h3f, 6'h00);
      gate(8'h80, 6'h3f, 6'h00);
   endtask
   task automatic unmapped();
      apb(1'b1, 8'ha9, 32'hff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'ha9, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `IEN_ADDR, 32'h0);
      chk(rd, 32'hc0);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      reset_read();
      reserved_bit();
      each_source();
      global_off();
      unmapped();
      test_done();
   end
endmodule
`default_nettype wire
